// ==== dpwm_params.svh ====
// Constants for the dual PWM and cascadable timer block.
//
// Function
// R1: Cascade bit joins timers, second is high.
// R2: Cascaded count matches period, reloads, sets flag.
// R3: Cascaded clock chosen by first select only.
// R4: Clear select counts instructions, set counts falls.
// R5: Both runs count; first only counts low.
// R6: External clock sampled twice per instruction.
// R7: PWM two base selectable; PWM one fixed.
// R8: PWM one enable forces pin as output.
// R9: PWM two enable forces pin likewise.
// R10: Duty is high byte plus two bits.
// R11: High time equals duty oscillator periods.
// R12: Zero duty keeps output low.
// R13: Duty high equal period ends low briefly.
// R14: Duty high above period gives full high.
// R15: Master copies to slave at rollover.
// R16: Duty reads return the slave latches.
// R17: Software avoids read-modify-write on duty.
// R18: Software never cascades while PWM used.
// R19: Resolution is at most ten bits.
// R20: Rollover flags latch; software clears them.
// R21: External base needs low duty bits clear.
// R22: Output falls when position reaches duty.
`ifndef DPWM_PARAMS_SVH
`define DPWM_PARAMS_SVH

// ****************************************
// Register banks and indices.
// ****************************************
`define DPWM_BANK_FLAG   2'h1
`define DPWM_BANK_TMR    2'h2
`define DPWM_BANK_PWM    2'h3
`define DPWM_IDX_FLAGS   5'h16
`define DPWM_IDX_TIMER_ONE_COUNT    5'h10
`define DPWM_IDX_TIMER_TWO_COUNT    5'h11
`define DPWM_IDX_PR1     5'h14
`define DPWM_IDX_PR2     5'h15
`define DPWM_IDX_DCL1    5'h10
`define DPWM_IDX_DCL2    5'h11
`define DPWM_IDX_DCH1    5'h12
`define DPWM_IDX_DCH2    5'h13
`define DPWM_IDX_TIMER_CONTROL_ONE   5'h16
`define DPWM_IDX_TIMER_CONTROL_TWO   5'h17

// ****************************************
// Field positions.
// ****************************************
`define DPWM_F_CS1       0
`define DPWM_F_CS2       1
`define DPWM_F_CASCADE   3
`define DPWM_F_RUN1      0
`define DPWM_F_RUN2      1
`define DPWM_F_PEN1      4
`define DPWM_F_PEN2      5
`define DPWM_F_FLAG1     4
`define DPWM_F_FLAG2     5
`define DPWM_F_BASE      5

// ****************************************
// Reset values and timing.
// ****************************************
`define DPWM_RST_BYTE    8'h00
`define DPWM_RST_FLAGS   8'h02
`define DPWM_RST_DUTY    10'h000
`define DPWM_Q_LAST      2'h3
`define DPWM_Q_MID       2'h1

`endif

// ==== dpwm_pkg.sv ====
// Types shared by the dual PWM and cascadable timer block.
package dpwm_pkg;
    typedef logic [7:0]  dpwm_byte_t;   // One register byte.
    typedef logic [9:0]  dpwm_duty_t;   // Ten-bit duty value.
    typedef logic [1:0]  dpwm_q_t;      // Q-phase within an instruction.
    typedef logic [31:0] dpwm_word_t;   // APB data word.
    typedef logic [8:0]  dpwm_addr_t;   // APB byte address.
endpackage

// ==== dpwm_core.sv ====
// Dual 10-bit PWM with two cascadable 8-bit timers and an APB slave.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "dpwm_params.svh"
module dpwm_core (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire dpwm_pkg::dpwm_addr_t paddr,
    input  wire dpwm_pkg::dpwm_word_t pwdata,
    output dpwm_pkg::dpwm_word_t    prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               external_timer_clock_pin,
    input  wire logic               port_one_data,
    input  wire logic               port_one_dir_in,
    input  wire logic               port_two_data,
    input  wire logic               port_two_dir_in,
    output logic                    pwm_one_pin_o,
    output logic                    pwm_one_pin_oe,
    output logic                    pwm_two_pin_o,
    output logic                    pwm_two_pin_oe
);
    import dpwm_pkg::*;

    localparam dpwm_byte_t flags_rst = `DPWM_RST_FLAGS; // Flag register reset image.
    // ****************************************
    // Declarations.
    // ****************************************
    dpwm_q_t    q_reg;                  // Q-phase counter.
    logic       inst_tick;              // Last Q-phase of an instruction.
    logic       samp_en;                // Twice per instruction sample.
    logic       samp1_reg;              // Synchroniser first stage.
    logic       samp2_reg;              // Synchroniser second stage.
    logic       samp3_reg;              // Edge history.
    logic       edge_fall;              // Falling edge seen.
    logic       pend_reg;               // Edge waiting for a tick.
    logic       ext_tick;               // External count tick.
    logic       cs1_reg;                // Timer one clock select.
    logic       cs2_reg;                // Timer two clock select.
    logic       cascade_select;         // Joins the two timers.
    logic       run1_reg;               // Timer one run.
    logic       run2_reg;               // Timer two run.
    logic       pen1_reg;               // PWM one enable.
    logic       pen2_reg;               // PWM two enable.
    logic       base_reg;               // PWM two base select.
    logic       flag1_reg;              // Timer one rollover flag.
    logic       flag2_reg;              // Timer two rollover flag.
    dpwm_byte_t cnt1_reg;               // Timer one count.
    dpwm_byte_t cnt2_reg;               // Timer two count.
    dpwm_byte_t per1_reg;               // Timer one period.
    dpwm_byte_t per2_reg;               // Timer two period.
    dpwm_byte_t dch1_reg;               // PWM one master high byte.
    dpwm_byte_t dch2_reg;               // PWM two master high byte.
    dpwm_q_t    dcl1_reg;               // PWM one master low bits.
    dpwm_q_t    dcl2_reg;               // PWM two master low bits.
    dpwm_duty_t duty1_reg;              // PWM one slave duty.
    dpwm_duty_t duty2_reg;              // PWM two slave duty.
    logic       wave1_reg;              // PWM one waveform.
    logic       wave2_reg;              // PWM two waveform.
    dpwm_byte_t cnt1_next;              // Timer one next count.
    dpwm_byte_t cnt2_next;              // Timer two next count.
    logic       roll1;                  // Timer one rollover pulse.
    logic       roll2;                  // Timer two rollover pulse.
    logic       roll_b2;                // PWM two base rollover.
    dpwm_byte_t base2_cnt;              // PWM two base count.
    logic       tick1;                  // Timer one count event.
    logic       tick2;                  // Timer two count event.
    logic       setup;                  // APB setup phase.
    logic       apb_wr;                 // Write taking effect.
    dpwm_byte_t wbyte;                  // Written byte.
    dpwm_byte_t rd_byte;                // Byte to be read.
    logic       rd_hit;                 // Address is mapped.

    // Address hit for a bank and index pair.
    function automatic logic hit(input dpwm_addr_t a, input logic [1:0] b,
                                 input logic [4:0] i);
        hit = (a == {b, i, 2'b00});
    endfunction

    // Sixteen-bit increment with period reload.
    function automatic logic [15:0] step16(input logic [15:0] c,
                                           input logic [15:0] p);
        step16 = (c == p) ? 16'h0000 : c + 16'h0001;
    endfunction

    // ****************************************
    // Q-phase and external clock sampling.
    // ****************************************
    assign inst_tick = (q_reg == `DPWM_Q_LAST);
    assign samp_en   = (q_reg == `DPWM_Q_MID) || inst_tick;
    assign edge_fall = samp3_reg && !samp2_reg;
    assign ext_tick  = inst_tick && (pend_reg || edge_fall);

    // Q-phase counter, four oscillator clocks per instruction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= 2'h0;
        end else begin
            q_reg <= q_reg + 2'h1;
        end
    end

    // Pin is sampled on two phases of every instruction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp1_reg <= 1'b1;
            samp2_reg <= 1'b1;
            samp3_reg <= 1'b1;
        end else if (samp_en) begin
            samp1_reg <= external_timer_clock_pin; // R6
            samp2_reg <= samp1_reg;
            samp3_reg <= samp2_reg;
        end
    end

    // A seen edge waits for the next instruction tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= !inst_tick && (pend_reg || edge_fall); // R6
        end
    end

    // ****************************************
    // Timer counting.
    // ****************************************
    // Cascaded mode takes its source from timer one only.
    assign tick1 = cs1_reg ? ext_tick : inst_tick; // R4
    assign tick2 = cascade_select ? tick1 : (cs2_reg ? ext_tick : inst_tick); // R3

    // Next counts and rollover pulses.
    always_comb begin
        cnt1_next = cnt1_reg;
        cnt2_next = cnt2_reg;
        roll1     = 1'b0;
        roll2     = 1'b0;
        if (cascade_select) begin
            if (run1_reg && tick1) begin
                if (run2_reg) begin
                    // Second timer is the upper byte.
                    {cnt2_next, cnt1_next} = step16({cnt2_reg, cnt1_reg},
                                                    {per2_reg, per1_reg}); // R1
                    roll1 = ({cnt2_reg, cnt1_reg} == {per2_reg, per1_reg}); // R2
                end else begin
                    // Only the low byte counts.
                    cnt1_next = cnt1_reg + 8'h01; // R5
                end
            end
        end else begin
            if (run1_reg && tick1) begin
                roll1     = (cnt1_reg == per1_reg);
                cnt1_next = roll1 ? 8'h00 : cnt1_reg + 8'h01;
            end
            if (run2_reg && tick2) begin
                roll2     = (cnt2_reg == per2_reg);
                cnt2_next = roll2 ? 8'h00 : cnt2_reg + 8'h01;
            end
        end
    end

    // Timer counts; a software write wins over counting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt1_reg <= `DPWM_RST_BYTE;
            cnt2_reg <= `DPWM_RST_BYTE;
        end else begin
            if (apb_wr && hit(paddr, `DPWM_BANK_TMR, `DPWM_IDX_TIMER_ONE_COUNT)) begin
                cnt1_reg <= wbyte;
            end else begin
                cnt1_reg <= cnt1_next;
            end
            if (apb_wr && hit(paddr, `DPWM_BANK_TMR, `DPWM_IDX_TIMER_TWO_COUNT)) begin
                cnt2_reg <= wbyte;
            end else begin
                cnt2_reg <= cnt2_next;
            end
        end
    end

    // Rollover flags; a rollover wins over a software clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag1_reg <= flags_rst[`DPWM_F_FLAG1];
            flag2_reg <= flags_rst[`DPWM_F_FLAG2];
        end else if (roll1 || roll2) begin
            flag1_reg <= flag1_reg || roll1; // R20
            flag2_reg <= flag2_reg || roll2;
        end else if (apb_wr && hit(paddr, `DPWM_BANK_FLAG, `DPWM_IDX_FLAGS)) begin
            flag1_reg <= wbyte[`DPWM_F_FLAG1];
            flag2_reg <= wbyte[`DPWM_F_FLAG2];
        end
    end

    // ****************************************
    // Control and master registers.
    // ****************************************
    // Software-written control, period and master duty latches.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs1_reg        <= 1'b0;
            cs2_reg        <= 1'b0;
            cascade_select <= 1'b0;
            run1_reg       <= 1'b0;
            run2_reg       <= 1'b0;
            pen1_reg       <= 1'b0;
            pen2_reg       <= 1'b0;
            base_reg       <= 1'b0;
            per1_reg       <= `DPWM_RST_BYTE;
            per2_reg       <= `DPWM_RST_BYTE;
            dch1_reg       <= `DPWM_RST_BYTE;
            dch2_reg       <= `DPWM_RST_BYTE;
            dcl1_reg       <= 2'h0;
            dcl2_reg       <= 2'h0;
        end else if (apb_wr) begin
            if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_TIMER_CONTROL_ONE)) begin
                cs1_reg        <= wbyte[`DPWM_F_CS1];
                cs2_reg        <= wbyte[`DPWM_F_CS2];
                cascade_select <= wbyte[`DPWM_F_CASCADE];
            end
            if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_TIMER_CONTROL_TWO)) begin
                run1_reg <= wbyte[`DPWM_F_RUN1];
                run2_reg <= wbyte[`DPWM_F_RUN2];
                pen1_reg <= wbyte[`DPWM_F_PEN1];
                pen2_reg <= wbyte[`DPWM_F_PEN2];
            end
            if (hit(paddr, `DPWM_BANK_TMR, `DPWM_IDX_PR1)) begin
                per1_reg <= wbyte;
            end
            if (hit(paddr, `DPWM_BANK_TMR, `DPWM_IDX_PR2)) begin
                per2_reg <= wbyte;
            end
            // Duty writes reach only the master latches.
            if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_DCH1)) begin
                dch1_reg <= wbyte; // R15
            end
            if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_DCH2)) begin
                dch2_reg <= wbyte; // R15
            end
            if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_DCL1)) begin
                dcl1_reg <= wbyte[7:6]; // R10
            end
            if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_DCL2)) begin
                dcl2_reg <= wbyte[7:6]; // R10
                base_reg <= wbyte[`DPWM_F_BASE];
            end
        end
    end

    // ****************************************
    // PWM generation.
    // ****************************************
    // PWM two follows timer one unless its base bit is set.
    assign roll_b2   = base_reg ? roll2 : roll1; // R7
    assign base2_cnt = base_reg ? cnt2_reg : cnt1_reg; // R7

    // Slave latches load from the masters as a period starts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty1_reg <= `DPWM_RST_DUTY;
            duty2_reg <= `DPWM_RST_DUTY;
        end else begin
            if (roll1) begin
                duty1_reg <= {dch1_reg, dcl1_reg}; // R15
            end
            if (roll_b2) begin
                duty2_reg <= {dch2_reg, dcl2_reg}; // R15
            end
        end
    end

    // High while count and Q-phase stay below duty, in oscillator steps.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave1_reg <= 1'b0;
            wave2_reg <= 1'b0;
        end else begin
            wave1_reg <= ({cnt1_reg, q_reg} < duty1_reg); // R11 R12 R13 R14 R19 R22
            wave2_reg <= ({base2_cnt, q_reg} < duty2_reg); // R11 R12 R13 R14 R22
        end
    end

    // Pins: an enabled PWM forces an output; else the port owns it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_one_pin_o  <= 1'b0;
            pwm_one_pin_oe <= 1'b0;
            pwm_two_pin_o  <= 1'b0;
            pwm_two_pin_oe <= 1'b0;
        end else begin
            pwm_one_pin_o  <= pen1_reg ? wave1_reg : port_one_data; // R8
            pwm_one_pin_oe <= pen1_reg || !port_one_dir_in; // R8
            pwm_two_pin_o  <= pen2_reg ? wave2_reg : port_two_data; // R9
            pwm_two_pin_oe <= pen2_reg || !port_two_dir_in; // R9
        end
    end

    // ****************************************
    // APB slave.
    // ****************************************
    assign setup  = psel && !penable;
    assign apb_wr = psel && penable && pwrite && rd_hit;
    assign wbyte  = pwdata[7:0];
    assign pready = 1'b1;

    // Read mux; duty registers return the slave latches.
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (hit(paddr, `DPWM_BANK_TMR, `DPWM_IDX_TIMER_ONE_COUNT)) begin
            rd_byte = cnt1_reg;
        end else if (hit(paddr, `DPWM_BANK_TMR, `DPWM_IDX_TIMER_TWO_COUNT)) begin
            rd_byte = cnt2_reg;
        end else if (hit(paddr, `DPWM_BANK_TMR, `DPWM_IDX_PR1)) begin
            rd_byte = per1_reg;
        end else if (hit(paddr, `DPWM_BANK_TMR, `DPWM_IDX_PR2)) begin
            rd_byte = per2_reg;
        end else if (hit(paddr, `DPWM_BANK_FLAG, `DPWM_IDX_FLAGS)) begin
            rd_byte = `DPWM_RST_FLAGS;
            rd_byte[`DPWM_F_FLAG1] = flag1_reg;
            rd_byte[`DPWM_F_FLAG2] = flag2_reg;
        end else if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_TIMER_CONTROL_ONE)) begin
            rd_byte[`DPWM_F_CS1]     = cs1_reg;
            rd_byte[`DPWM_F_CS2]     = cs2_reg;
            rd_byte[`DPWM_F_CASCADE] = cascade_select;
        end else if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_TIMER_CONTROL_TWO)) begin
            rd_byte[`DPWM_F_RUN1] = run1_reg;
            rd_byte[`DPWM_F_RUN2] = run2_reg;
            rd_byte[`DPWM_F_PEN1] = pen1_reg;
            rd_byte[`DPWM_F_PEN2] = pen2_reg;
        end else if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_DCH1)) begin
            rd_byte = duty1_reg[9:2]; // R16
        end else if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_DCH2)) begin
            rd_byte = duty2_reg[9:2]; // R16
        end else if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_DCL1)) begin
            rd_byte[7:6] = duty1_reg[1:0]; // R16
        end else if (hit(paddr, `DPWM_BANK_PWM, `DPWM_IDX_DCL2)) begin
            rd_byte[7:6]          = duty2_reg[1:0]; // R16
            rd_byte[`DPWM_F_BASE] = base_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read data and error are captured in the setup phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= {24'h00_0000, rd_byte};
            pslverr <= !rd_hit;
        end
    end

    // ****************************************
    // Assertions.
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_three_quiet;
        !inst_tick [*3];
    endsequence

    property p_inst_rate;
        inst_tick |=> s_three_quiet ##1 inst_tick;
    endproperty
    a_inst_rate: assert property (p_inst_rate) else $error("bad rate"); // R4

    property p_cascade_reload;
        (roll1 && cascade_select && !apb_wr) |=>
            ({cnt2_reg, cnt1_reg} == 16'h0000) && flag1_reg;
    endproperty
    a_cascade_reload: assert property (p_cascade_reload) else $error("no reload"); // R2

    property p_stopped;
        (!run1_reg && !apb_wr) |=> $stable(cnt1_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped timer moved"); // R5

    property p_low_only;
        (cascade_select && !run2_reg && !apb_wr) |=> $stable(cnt2_reg);
    endproperty
    a_low_only: assert property (p_low_only) else $error("high byte moved"); // R5

    property p_pin_force;
        pen1_reg |=> pwm_one_pin_oe && (pwm_one_pin_o == $past(wave1_reg));
    endproperty
    a_pin_force: assert property (p_pin_force) else $error("pin not forced"); // R8

    property p_zero_duty;
        (duty1_reg == 10'h000) |=> !wave1_reg;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty high"); // R12

    property p_full_duty;
        (duty1_reg[9:2] > per1_reg && cnt1_reg <= per1_reg) |=> wave1_reg;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty low"); // R14

    sequence s_load;
        roll1 && (dch1_reg != 8'h00) && !apb_wr;
    endsequence

    property p_slave_load;
        s_load |=> (duty1_reg == $past({dch1_reg, dcl1_reg})) ##1 wave1_reg;
    endproperty
    a_slave_load: assert property (p_slave_load) else $error("no period start"); // R15

    property p_ext_edge;
        (ext_tick && cs1_reg && run1_reg && !apb_wr) |=>
            (cnt1_reg != $past(cnt1_reg)) || $past(roll1);
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("edge not counted"); // R6

endmodule

// ==== dpwm_tb_top.sv ====
// Self-checking testbench for the dual PWM and cascadable timer block.
`timescale 1ns/1ps
module dpwm_tb_top;
    import dpwm_pkg::*;
    // One access: address, write, data, expected read byte, expected error.
    typedef struct {dpwm_addr_t a; logic w; dpwm_byte_t d; dpwm_byte_t x; logic e;} dpwm_row_s;
    // One duty setting and its high pclk count over two periods of 16 pclk.
    typedef struct {dpwm_byte_t h; dpwm_byte_t l; dpwm_byte_t x;} dpwm_duty_s;
    logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
    logic       external_timer_clock_pin, port_one_data, port_one_dir_in;
    logic       port_two_data, port_two_dir_in, pwm_one_pin_o, pwm_one_pin_oe;
    logic       pwm_two_pin_o, pwm_two_pin_oe;
    dpwm_addr_t paddr;
    dpwm_word_t pwdata, prdata;
    dpwm_byte_t rv;
    int         fails, n_tests, cyc, hi;
    // Reset values, read-write, a duty read that shows the slave, an unmapped place.
    dpwm_row_s  rows [8] = '{
        '{9'h1d8, 1'b0, 8'h00, 8'h00, 1'b0}, '{9'h1dc, 1'b0, 8'h00, 8'h00, 1'b0},
        '{9'h0d8, 1'b0, 8'h00, 8'h02, 1'b0}, '{9'h150, 1'b1, 8'h5a, 8'h00, 1'b0},
        '{9'h150, 1'b0, 8'h00, 8'h5a, 1'b0}, '{9'h1c8, 1'b1, 8'h80, 8'h00, 1'b0},
        '{9'h1c8, 1'b0, 8'h00, 8'h00, 1'b0}, '{9'h1fc, 1'b0, 8'h00, 8'h00, 1'b1}};
    // Zero duty, partial duty, duty high equal to the period, duty high above it.
    dpwm_duty_s duty [4] = '{'{8'h00, 8'h00, 8'h00}, '{8'h01, 8'h80, 8'h0c},
        '{8'h03, 8'h40, 8'h1a}, '{8'h04, 8'h00, 8'h20}};

    dpwm_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_timer_clock_pin, .port_one_data, .port_one_dir_in,
        .port_two_data, .port_two_dir_in, .pwm_one_pin_o, .pwm_one_pin_oe,
        .pwm_two_pin_o, .pwm_two_pin_oe);

    // ****************************************
    // Clock, timeout and helpers.
    // ****************************************
    // The 200 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Counts cycles so that a hang ends the run as a mismatch.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    // Compares one byte and reports a mismatch at once.
    task automatic chk_byte(input dpwm_byte_t got, input dpwm_byte_t exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic apb(input dpwm_addr_t a, input logic w, input dpwm_byte_t d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata[7:0];
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so that the next call never drives psel twice at once.
        @(posedge pclk);
    endtask
    task automatic wr(input dpwm_addr_t a, input dpwm_byte_t d);
        apb(a, 1'b1, d);
    endtask
    // Reads a register and compares it.
    task automatic rdc(input dpwm_addr_t a, input dpwm_byte_t x);
        apb(a, 1'b0, 8'h00);
        chk_byte(rv, x);
    endtask
    // Counts high cycles of one PWM pin, sampled mid-cycle where it is settled.
    task automatic measure(input logic two);
        hi = 0;
        repeat (32) begin
            @(negedge pclk);
            hi += int'(two ? pwm_two_pin_o === 1'b1 : pwm_one_pin_o === 1'b1);
        end
        @(posedge pclk);
    endtask
    // Reads a register until the masked value appears, with a bounded count of reads.
    task automatic poll(input dpwm_addr_t a, input dpwm_byte_t m, input dpwm_byte_t x);
        for (int i = 0; i < 30; i++) begin
            apb(a, 1'b0, 8'h00);
            if ((rv & m) === x) break;
        end
        chk_byte(rv & m, x);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("compares %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, port_one_data, port_two_data} = 6'h00;
        {external_timer_clock_pin, port_one_dir_in, port_two_dir_in} = 3'h7;
        paddr = 9'h000;
        pwdata = 32'h00000000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk_byte(rv, rows[i].x);
            if (!rows[i].w) chk_byte({7'h00, re}, {7'h00, rows[i].e});
        end
        $display("test registers done");
        // PWM one on timer one, period of four instructions, pin forced out.
        wr(9'h150, 8'h03);
        wr(9'h1dc, 8'h11);
        foreach (duty[i]) begin
            wr(9'h1c8, duty[i].h);
            wr(9'h1c0, duty[i].l);
            repeat (24) @(posedge pclk);
            measure(1'b0);
            chk_byte(8'(hi), duty[i].x);
            chk_byte({7'h00, pwm_one_pin_oe}, 8'h01);
            rdc(9'h1c8, duty[i].h);
        end
        // PWM two on timer two with a duty of three Q-steps out of eight.
        wr(9'h154, 8'h01);
        wr(9'h1cc, 8'h00);
        wr(9'h1c4, 8'he0);
        wr(9'h1dc, 8'h33);
        repeat (24) @(posedge pclk);
        measure(1'b1);
        chk_byte(8'(hi), 8'h0c);
        rdc(9'h1c4, 8'he0);
        // Both outputs disabled: the pins go back to the port.
        wr(9'h1dc, 8'h03);
        port_one_dir_in <= 1'b0;
        port_one_data <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_byte({6'h00, pwm_one_pin_oe, pwm_one_pin_o}, 8'h03);
        chk_byte({7'h00, pwm_two_pin_oe}, 8'h00);
        $display("test pwm done");
        // Cascade with period 0x0101 from 0x00fe: carry, then reload and flag.
        wr(9'h1dc, 8'h00);
        wr(9'h1d8, 8'h08);
        wr(9'h150, 8'h01);
        wr(9'h140, 8'hfe);
        wr(9'h144, 8'h00);
        wr(9'h0d8, 8'h00);
        wr(9'h1dc, 8'h03);
        poll(9'h144, 8'hff, 8'h01);
        poll(9'h0d8, 8'h10, 8'h10);
        wr(9'h1dc, 8'h00);
        rdc(9'h144, 8'h00);
        // Only the first run bit: low byte wraps alone, no flag.
        wr(9'h0d8, 8'h00);
        wr(9'h140, 8'hfe);
        wr(9'h1dc, 8'h01);
        repeat (40) @(posedge pclk);
        wr(9'h1dc, 8'h02);
        rdc(9'h0d8, 8'h02);
        // First run bit clear: the counter holds.
        wr(9'h140, 8'h10);
        repeat (40) @(posedge pclk);
        rdc(9'h140, 8'h10);
        // External clock chosen by the first select: five falling edges.
        wr(9'h1d8, 8'h09);
        wr(9'h140, 8'h00);
        wr(9'h1dc, 8'h03);
        repeat (5) begin
            external_timer_clock_pin <= 1'b0;
            repeat (8) @(posedge pclk);
            external_timer_clock_pin <= 1'b1;
            repeat (8) @(posedge pclk);
        end
        repeat (12) @(posedge pclk);
        wr(9'h1dc, 8'h00);
        rdc(9'h140, 8'h05);
        // Second select set alone is ignored: internal counting goes on.
        wr(9'h1d8, 8'h0a);
        wr(9'h1dc, 8'h03);
        repeat (40) @(posedge pclk);
        wr(9'h1dc, 8'h00);
        apb(9'h140, 1'b0, 8'h00);
        chk_byte({7'h00, rv > 8'h0d}, 8'h01);
        $display("test timers done");
        complete_run();
    end
endmodule
